// ===== adof_pkg.sv
package adof_pkg;
	// Register byte offsets on the APB slave
	localparam logic [11:0] ADOF_REG_CLK_CTRL = 12'h000;
	localparam logic [11:0] ADOF_REG_DRIVER   = 12'h004;
	localparam logic [11:0] ADOF_REG_FORMAT   = 12'h008;
	localparam logic [11:0] ADOF_REG_STATUS   = 12'h00C;

	// Clock control register fields
	localparam int ADOF_CC_DCS_BIT   = 0;
	localparam int ADOF_CC_PHASE_LSB = 1;
	localparam int ADOF_CC_INV_BIT   = 3;
	localparam logic [3:0] ADOF_CC_RESET = 4'h0;

	// Output driver register fields
	localparam int ADOF_DRV_CUR_LSB  = 0;
	localparam int ADOF_DRV_TERM_BIT = 3;
	localparam logic [2:0] ADOF_CUR_3P5MA = 3'h4;
	localparam logic [2:0] ADOF_CUR_MAX   = 3'h6;
	localparam logic [3:0] ADOF_DRV_RESET = {1'b0, ADOF_CUR_3P5MA};

	// Current levels in units of 0.05 mA
	localparam logic [7:0] ADOF_I_1P75 = 8'h23;
	localparam logic [7:0] ADOF_I_2P1  = 8'h2A;
	localparam logic [7:0] ADOF_I_2P5  = 8'h32;
	localparam logic [7:0] ADOF_I_3P0  = 8'h3C;
	localparam logic [7:0] ADOF_I_3P5  = 8'h46;
	localparam logic [7:0] ADOF_I_4P0  = 8'h50;
	localparam logic [7:0] ADOF_I_4P5  = 8'h5A;

	// Data format register fields
	localparam int ADOF_FMT_TWOS_BIT = 0;
	localparam logic ADOF_FMT_RESET  = 1'b0;

	// Sample codes
	localparam int ADOF_SAMPLE_W = 12;
	localparam int ADOF_PAIRS    = 6;
	localparam logic [11:0] ADOF_CODE_POS_FS = 12'hFFF;
	localparam logic [11:0] ADOF_CODE_NEG_FS = 12'h000;

	// Encode period measurement and stabilizer lock
	localparam int ADOF_PER_W = 8;
	localparam logic [7:0] ADOF_PER_STOP   = 8'hFF;
	localparam logic [6:0] ADOF_LOCK_COUNT = 7'h64;
	localparam int ADOF_DLY_DEPTH = 128;
endpackage

// ===== adof_top.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - One 12-bit sample per encode period, sent over six DDR pairs.
// - Even bit while forwarded clock low, odd bit while it is high.
// - Without phase shift, data changes together with both clock edges.
// - Each rising edge of the positive encode input starts a conversion.
// - Driver current resets to the 3.5mA level.
// - Current field selects one of seven levels, 1.75mA to 4.5mA.
// - Termination bit enables internal termination and doubles effective current.
// - Range flag shows over or under range with the data latency.
// - With invert clear, range flag is valid in the clock low phase.
// - Two-bit field delays the forwarded clock by 0 to 135 degrees while the stabilizer is on.
// - Invert bit flips clock polarity independently, giving up to 315 degrees.
// - Format resets to offset binary; a bit selects two's complement.
// - Mid-scale is 800 hex; two's complement inverts the top bit.
// - Out of range sets the flag and holds the full-scale code.
// - Stabilizer regenerates 50% duty and locks after one hundred cycles.
// - Stabilizer enable comes from register or chip-select pin by mode.
module adof_top
	import adof_pkg::*;
(
	input  wire logic        clock,                  // 100 MHz system clock
	input  wire logic        rst,                    // Synchronous reset, high
	input  wire logic        encode_input_pos,       // Encode clock, positive leg
	input  wire logic        encode_input_neg,       // Encode clock, negative leg
	input  wire logic [11:0] core_code,              // Converter core code, offset binary
	input  wire logic        core_over,              // Core input above full scale
	input  wire logic        core_under,             // Core input below full scale
	input  wire logic        config_mode_select,     // 1 selects parallel configuration
	input  wire logic        par_dcs_pin,            // Chip-select level, parallel mode
	input  wire logic        psel,                   // APB select
	input  wire logic        penable,                // APB enable
	input  wire logic        pwrite,                 // APB direction
	input  wire logic [11:0] paddr,                  // APB byte address
	input  wire logic [31:0] pwdata,                 // APB write data
	output logic             pready,                 // APB ready
	output logic [31:0]      prdata,                 // APB read data
	output logic             pslverr,                // APB error, unmapped address
	output logic [5:0]       data_pair,              // DDR data pairs, bit 0 is lowest
	output logic             range_flag,             // Over or under range flag
	output logic             forwarded_output_clock, // Forwarded data clock
	output logic [7:0]       driver_current_eff,     // Driver current, 0.05 mA units
	output logic             driver_term_en,         // Internal termination enable
	output logic             dcs_locked              // Stabilizer lock status
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [2:0]  encp_sync_q;
	logic [1:0]  encn_sync_q;
	logic [11:0] code_m_q, code_s_q;
	logic [1:0]  over_sync_q, under_sync_q, mode_sync_q, cs_sync_q;
	logic [3:0]  cc_q;
	logic [3:0]  drv_q;
	logic        fmt_q;
	logic [7:0]  per_cnt_q, per_q;
	logic [6:0]  lock_cnt_q;
	logic        fmt_s_q, inv_s_q;
	logic [1:0]  ph_s_q;
	logic [11:0] sample_q;
	logic        flag_q;
	logic        half_q;
	logic [ADOF_DLY_DEPTH-1:0] dly_q;
	// Stabilizer enable is read by the status mux ahead of its own logic
	wire         dcs_eff;

	// Level of each current code; used for the output only
	function automatic logic [7:0] cur_level(input logic [2:0] code);
		unique case (code)
			3'h0:    cur_level = ADOF_I_1P75;
			3'h1:    cur_level = ADOF_I_2P1;
			3'h2:    cur_level = ADOF_I_2P5;
			3'h3:    cur_level = ADOF_I_3P0;
			3'h4:    cur_level = ADOF_I_3P5;
			3'h5:    cur_level = ADOF_I_4P0;
			default: cur_level = ADOF_I_4P5;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers; first stages feed only the second stages
	always_ff @(posedge clock) begin
		encp_sync_q  <= {encp_sync_q[1:0], encode_input_pos};
		encn_sync_q  <= {encn_sync_q[0], encode_input_neg};
		code_m_q     <= core_code;
		code_s_q     <= code_m_q;
		over_sync_q  <= {over_sync_q[0], core_over};
		under_sync_q <= {under_sync_q[0], core_under};
		mode_sync_q  <= {mode_sync_q[0], config_mode_select};
		cs_sync_q    <= {cs_sync_q[0], par_dcs_pin};
	end

	// Edge detection on the settled stages; negative leg taken as a cross-check
	wire enc_hi   = encp_sync_q[1] & ~encn_sync_q[1];
	wire enc_rise = enc_hi & ~encp_sync_q[2];
	wire enc_fall = ~encp_sync_q[1] & encp_sync_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire        apb_acc   = psel & penable & ~pready;
	wire        apb_done  = psel & penable & pready;
	wire        hit_cc    = (paddr == ADOF_REG_CLK_CTRL);
	wire        hit_drv   = (paddr == ADOF_REG_DRIVER);
	wire        hit_fmt   = (paddr == ADOF_REG_FORMAT);
	wire        hit_st    = (paddr == ADOF_REG_STATUS);
	wire        hit_any   = hit_cc | hit_drv | hit_fmt | hit_st;
	wire        wr_en     = apb_done & pwrite;
	wire [2:0]  wr_cur    = pwdata[ADOF_DRV_CUR_LSB +: 3];
	wire        wr_cur_ok = (wr_cur <= ADOF_CUR_MAX);
	wire [31:0] rd_mux    = hit_cc  ? {28'h0000000, cc_q} :
	                        hit_drv ? {28'h0000000, drv_q} :
	                        hit_fmt ? {31'h00000000, fmt_q} :
	                        hit_st  ? {22'h000000, per_q, dcs_eff, dcs_locked} :
	                        32'h00000000;

	// One wait state so that ready and read data leave flip-flops
	always_ff @(posedge clock) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_acc;
			prdata  <= apb_acc & ~pwrite ? rd_mux : 32'h00000000;
			pslverr <= apb_acc & ~hit_any;
		end
	end

	// Configuration registers; writes land on the completing edge only
	always_ff @(posedge clock) begin
		if (rst) begin
			cc_q  <= ADOF_CC_RESET;
			drv_q <= ADOF_DRV_RESET;
			fmt_q <= ADOF_FMT_RESET;
		end else if (wr_en) begin
			if (hit_cc)
				cc_q <= pwdata[3:0];
			if (hit_drv && wr_cur_ok)
				drv_q <= pwdata[3:0];
			if (hit_fmt)
				fmt_q <= pwdata[ADOF_FMT_TWOS_BIT];
		end
	end

	wire [7:0] cur_lvl = cur_level(drv_q[2:0]); // Programmed level before doubling

	// Driver settings; an illegal current code is refused and keeps the old one
	always_ff @(posedge clock) begin
		if (rst) begin
			driver_current_eff <= ADOF_I_3P5;
			driver_term_en     <= 1'b0;
		end else begin
			driver_term_en     <= drv_q[ADOF_DRV_TERM_BIT];
			driver_current_eff <= drv_q[ADOF_DRV_TERM_BIT] ?
				{cur_lvl[6:0], 1'b0} : cur_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stabilizer: period measurement and lock tracking
	assign dcs_eff = mode_sync_q[1] ? cs_sync_q[1] : cc_q[ADOF_CC_DCS_BIT];
	wire per_stop = (per_cnt_q == ADOF_PER_STOP);
	wire per_same = (per_cnt_q == per_q) || (per_cnt_q == per_q + 8'h01) ||
	                (per_cnt_q + 8'h01 == per_q);
	wire [7:0] half_pt = {1'b0, per_q[7:1]};

	// A stopped or retimed encode clock restarts the lock count
	always_ff @(posedge clock) begin
		if (rst) begin
			per_cnt_q  <= 8'h00;
			per_q      <= 8'h00;
			lock_cnt_q <= 7'h00;
			dcs_locked <= 1'b0;
		end else begin
			per_cnt_q <= enc_rise ? 8'h01 : (per_stop ? per_cnt_q : per_cnt_q + 8'h01);
			if (enc_rise)
				per_q <= per_cnt_q;
			if (per_stop || !dcs_eff)
				lock_cnt_q <= 7'h00;
			else if (enc_rise)
				lock_cnt_q <= !per_same ? 7'h00 :
					(lock_cnt_q == ADOF_LOCK_COUNT ? lock_cnt_q : lock_cnt_q + 7'h01);
			dcs_locked <= (lock_cnt_q == ADOF_LOCK_COUNT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample capture, clamp and format at the encode boundary
	wire        ovr      = over_sync_q[1];
	wire        und      = under_sync_q[1] & ~over_sync_q[1];
	wire [11:0] clamped  = ovr ? ADOF_CODE_POS_FS : (und ? ADOF_CODE_NEG_FS : code_s_q);
	wire [11:0] formatted = {clamped[11] ^ fmt_q, clamped[10:0]};

	// Settings shadowed here so no sample mixes old and new formatting
	always_ff @(posedge clock) begin
		if (rst) begin
			sample_q <= ADOF_CODE_NEG_FS;
			flag_q   <= 1'b0;
			fmt_s_q  <= ADOF_FMT_RESET;
			ph_s_q   <= 2'h0;
			inv_s_q  <= 1'b0;
		end else if (enc_rise) begin
			sample_q <= formatted;
			flag_q   <= ovr | und;
			fmt_s_q  <= fmt_q;
			ph_s_q   <= dcs_eff ? cc_q[ADOF_CC_PHASE_LSB +: 2] : 2'h0;
			inv_s_q  <= cc_q[ADOF_CC_INV_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Half-period phase: stabilizer regenerates 50%, else encode duty is kept
	wire half_hit = dcs_eff ? (per_cnt_q == half_pt) : enc_fall;

	always_ff @(posedge clock) begin
		if (rst)
			half_q <= 1'b0;
		else if (enc_rise)
			half_q <= 1'b0;
		else if (half_hit)
			half_q <= 1'b1;
	end

	// Clock delay line; an eighth of the period per 45 degree step
	wire [6:0] ph_dly  = 7'(ph_s_q * per_q[7:3]);
	wire       clk_dly = (ph_dly == 7'h00) ? half_q : dly_q[ph_dly - 7'h01];

	always_ff @(posedge clock) begin
		if (rst)
			dly_q <= '0;
		else
			dly_q <= {dly_q[ADOF_DLY_DEPTH-2:0], half_q};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pair multiplexers: even bit in the first half, odd bit in the second
	wire [5:0] pair_d;
	genvar gi;
	generate
		for (gi = 0; gi < ADOF_PAIRS; gi++) begin : g_pair
			assign pair_d[gi] = half_q ? sample_q[2*gi+1] : sample_q[2*gi];
		end
	endgenerate

	// Data, flag and clock launched on the same edge so they stay aligned
	always_ff @(posedge clock) begin
		if (rst) begin
			data_pair              <= 6'h00;
			range_flag             <= 1'b0;
			forwarded_output_clock <= 1'b0;
		end else begin
			data_pair              <= pair_d;
			range_flag             <= flag_q & ~half_q;
			forwarded_output_clock <= clk_dly ^ inv_s_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_drv_reset_val: assert property ($past(rst) |-> drv_q[2:0] == ADOF_CUR_3P5MA)
		else $error("driver current not at 3.5mA after reset");
	chk_cur_code_range: assert property (drv_q[2:0] <= ADOF_CUR_MAX)
		else $error("driver current code out of range");
	chk_term_doubles: assert property ($stable(drv_q) && drv_q[ADOF_DRV_TERM_BIT]
		|=> driver_term_en && driver_current_eff[0] == 1'b0)
		else $error("termination did not double current");
	chk_flag_high_half: assert property (half_q |=> !range_flag)
		else $error("range flag set in second half");
	chk_flag_follows: assert property (!half_q && flag_q |=> range_flag)
		else $error("range flag lost in first half");
	chk_clamp_over: assert property (enc_rise && ovr
		|=> flag_q && sample_q[10:0] == ADOF_CODE_POS_FS[10:0])
		else $error("overrange not clamped");
	chk_twos_msb: assert property (enc_rise && !ovr && !und && fmt_q
		|=> sample_q[11] == !$past(code_s_q[11]))
		else $error("two's complement msb wrong");
	chk_even_low: assert property (!half_q && ph_s_q == 2'h0 && !inv_s_q
		|=> !forwarded_output_clock && data_pair[0] == $past(sample_q[0]))
		else $error("even bit not with clock low");
	chk_rise_restart: assert property (enc_rise |=> !half_q)
		else $error("conversion did not start on encode rise");
	chk_boundary_only: assert property (!enc_rise |=> $stable(fmt_s_q) && $stable(ph_s_q)
		&& $stable(inv_s_q))
		else $error("setting changed inside a sample");
	chk_stop_unlock: assert property (per_stop |=> ##1 !dcs_locked)
		else $error("lock held with encode stopped");
	chk_phase_gated: assert property (enc_rise && !dcs_eff |=> ph_s_q == 2'h0)
		else $error("phase applied without stabilizer");

	// Upper half and inverted clock: odd bits and polarity follow the settings
	chk_odd_high: assert property (half_q && ph_s_q == 2'h0 && !inv_s_q
		|=> forwarded_output_clock && data_pair[0] == $past(sample_q[1]))
		else $error("odd bit not with clock high");
	chk_inv_even: assert property (!half_q && ph_s_q == 2'h0 && inv_s_q
		|=> forwarded_output_clock)
		else $error("inverted clock not high in first half");

	// Reset values that software relies on before the first write
	chk_fmt_default: assert property ($past(rst) |-> fmt_q == ADOF_FMT_RESET)
		else $error("format not offset binary after reset");
	chk_cur_reset_out: assert property ($past(rst)
		|-> driver_current_eff == ADOF_I_3P5 && !driver_term_en)
		else $error("driver outputs not at reset level");

	// Clamping and formatting of in-range and under-range samples
	chk_under_clamp: assert property (enc_rise && und
		|=> flag_q && sample_q[10:0] == ADOF_CODE_NEG_FS[10:0])
		else $error("underrange not clamped");
	chk_offset_pass: assert property (enc_rise && !ovr && !und && !fmt_q
		|=> sample_q == $past(code_s_q))
		else $error("offset binary code altered");
	chk_flag_latency: assert property (enc_rise
		|=> flag_q == $past(over_sync_q[1] | under_sync_q[1]))
		else $error("range flag not taken with its sample");

	// Driver register: refused codes leave it alone, termination follows its bit
	chk_drv_refused: assert property (wr_en && hit_drv && !wr_cur_ok
		|=> $stable(drv_q))
		else $error("refused current code was written");
	chk_term_clear: assert property (!drv_q[ADOF_DRV_TERM_BIT] |=> !driver_term_en)
		else $error("termination on with its bit clear");

	// Lock status only after the full count, and dropped when disabled
	chk_lock_count: assert property ($rose(dcs_locked)
		|-> $past(lock_cnt_q) == ADOF_LOCK_COUNT)
		else $error("lock reported before full count");
	chk_dcs_off_unlock: assert property (!dcs_eff |=> ##1 !dcs_locked)
		else $error("lock held with stabilizer off");

	// Main scenarios that should each be seen at least once

	cov_locked: cover property ($rose(dcs_locked));
	cov_overrange: cover property (range_flag ##1 !range_flag);
	cov_inverted_shift: cover property (enc_rise && inv_s_q && ph_s_q == 2'h3);
	cov_twos_sample: cover property (enc_rise && fmt_q && !ovr && !und);
	cov_phase_shift: cover property (enc_rise && ph_s_q != 2'h0 && !inv_s_q);
endmodule

// ===== adof_rx_model.sv
`timescale 1ns/1ps
// Far-side receiver: builds words from the two halves of the forwarded clock
module adof_rx_model
	import adof_pkg::*;
(
	input  wire logic        clock,       // System clock
	input  wire logic        rst,         // Synchronous reset
	input  wire logic [5:0]  data_pair,   // DDR data pairs
	input  wire logic        range_flag,  // Range flag
	input  wire logic        fwd_clk,     // Forwarded clock
	input  wire logic        clk_inv,     // Receiver's view of the invert bit
	output logic      [11:0] rx_word,     // Last whole sample
	output logic             rx_flag,     // Flag seen in first half
	output logic             rx_flag_odd, // Flag seen in second half
	output int               rx_count     // Words received
);
	logic [5:0] even_q;
	logic [5:0] odd_q;
	logic       fl_q;
	logic       fo_q;
	logic       odd_seen_q;
	// A word closes when the clock returns to its first-half level
	always_ff @(posedge clock) begin
		if (rst) begin
			rx_count <= 0;
			odd_seen_q <= 1'b0;
		end else if (fwd_clk == clk_inv) begin
			if (odd_seen_q) begin
				for (int i = 0; i < 6; i++) begin
					rx_word[2*i] <= even_q[i];
					rx_word[2*i+1] <= odd_q[i];
				end
				rx_flag <= fl_q;
				rx_flag_odd <= fo_q;
				rx_count <= rx_count + 1;
			end
			even_q <= data_pair;
			fl_q <= range_flag;
			odd_seen_q <= 1'b0;
		end else begin
			odd_q <= data_pair;
			fo_q <= range_flag;
			odd_seen_q <= 1'b1;
		end
	end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb
	import adof_pkg::*;
;
	logic clock, rst, encode_input_pos, encode_input_neg, core_over, core_under;
	logic config_mode_select, par_dcs_pin, psel, penable, pwrite, pready, pslverr;
	logic range_flag, forwarded_output_clock, driver_term_en, dcs_locked;
	logic clk_inv, rx_flag, rx_flag_odd, er;
	logic [11:0] core_code, paddr, rx_word;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  data_pair;
	logic [7:0]  driver_current_eff;
	int          mismatches, checks, rx_count;
	adof_top dut (.clock(clock), .rst(rst), .encode_input_pos(encode_input_pos),
		.encode_input_neg(encode_input_neg), .core_code(core_code), .core_over(core_over),
		.core_under(core_under), .config_mode_select(config_mode_select),
		.par_dcs_pin(par_dcs_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.data_pair(data_pair), .range_flag(range_flag),
		.forwarded_output_clock(forwarded_output_clock),
		.driver_current_eff(driver_current_eff), .driver_term_en(driver_term_en),
		.dcs_locked(dcs_locked));
	adof_rx_model rx (.clock(clock), .rst(rst), .data_pair(data_pair), .range_flag(range_flag),
		.fwd_clk(forwarded_output_clock), .clk_inv(clk_inv), .rx_word(rx_word),
		.rx_flag(rx_flag), .rx_flag_odd(rx_flag_odd), .rx_count(rx_count));
	////////////////////////////////////////////////////////////////////////
	// Clocks; encode is 50% duty so it is valid with the stabilizer off
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		encode_input_pos = 1'b0;
		#3;
		forever #80 encode_input_pos = ~encode_input_pos;
	end
	assign encode_input_neg = ~encode_input_pos;
	////////////////////////////////////////////////////////////////////////
	// APB master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for k fresh words from the receiver, bounded
	task automatic wait_words(input int k);
		int c0;
		int n;
		c0 = rx_count;
		for (n = 0; n < 400 && rx_count < c0 + k; n++) @(posedge clock);
		`CHK("word wait", 1'b1, (n < 400))
	endtask
	task automatic samp(input logic [11:0] c, input logic ov, input logic un,
		input logic [11:0] ew, input logic ef);
		core_code <= c;
		core_over <= ov;
		core_under <= un;
		wait_words(4);
		`CHK("rx word", ew, rx_word)
		`CHK("flag low", ef, rx_flag)
		`CHK("flag high", 1'b0, rx_flag_odd)
	endtask
	// Lag from the start of an odd half to the clock reaching its odd level
	task automatic meas(input int e);
		int n;
		logic [5:0] pv;
		pv = data_pair;
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			if (pv === 6'h00 && data_pair === 6'h3F) break;
			pv = data_pair;
		end
		for (n = 0; n < 40 && forwarded_output_clock !== ~clk_inv; n++) @(posedge clock);
		`CHK("clock lag", e, n)
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		apb(0, ADOF_REG_CLK_CTRL, 32'h0);
		`CHK("clk ctrl", {28'h0, ADOF_CC_RESET}, rd)
		apb(0, ADOF_REG_DRIVER, 32'h0);
		`CHK("driver", {28'h0, ADOF_DRV_RESET}, rd)
		`CHK("current", ADOF_I_3P5, driver_current_eff)
		apb(0, ADOF_REG_FORMAT, 32'h0);
		`CHK("format", 32'h0, rd)
		apb(0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
		$display("test regs done");
	endtask
	task automatic t_current;
		logic [7:0] lv [7];
		lv = '{ADOF_I_1P75, ADOF_I_2P1, ADOF_I_2P5, ADOF_I_3P0, ADOF_I_3P5, ADOF_I_4P0, ADOF_I_4P5};
		for (int i = 0; i < 7; i++) begin
			apb(1, ADOF_REG_DRIVER, i);
			repeat (3) @(posedge clock);
			`CHK("current", lv[i], driver_current_eff)
		end
		apb(1, ADOF_REG_DRIVER, 32'h0000000C);
		repeat (3) @(posedge clock);
		`CHK("term current", lv[4] << 1, driver_current_eff)
		`CHK("term en", 1'b1, driver_term_en)
		apb(1, ADOF_REG_DRIVER, 32'h00000007);
		repeat (3) @(posedge clock);
		`CHK("code 7", lv[4] << 1, driver_current_eff)
		$display("test current done");
	endtask
	task automatic t_format;
		samp(12'h800, 0, 0, 12'h800, 0);
		samp(12'h5A3, 0, 0, 12'h5A3, 0);
		samp(12'h123, 1, 0, 12'hFFF, 1);
		apb(1, ADOF_REG_FORMAT, 32'h1);
		samp(12'h800, 0, 0, 12'h000, 0);
		samp(12'hFFF, 0, 0, 12'h7FF, 0);
		samp(12'h456, 0, 1, 12'h800, 1);
		apb(1, ADOF_REG_FORMAT, 32'h0);
		samp(12'h456, 0, 1, 12'h000, 1);
		$display("test format done");
	endtask
	task automatic t_par;
		config_mode_select <= 1'b1;
		repeat (8) @(posedge clock);
		apb(0, ADOF_REG_STATUS, 32'h0);
		`CHK("par off", 1'b0, rd[1])
		par_dcs_pin <= 1'b1;
		repeat (8) @(posedge clock);
		apb(0, ADOF_REG_STATUS, 32'h0);
		`CHK("par on", 1'b1, rd[1])
		config_mode_select <= 1'b0;
		par_dcs_pin <= 1'b0;
		$display("test parallel done");
	endtask
	task automatic t_phase;
		core_code <= 12'hAAA;
		core_over <= 1'b0;
		core_under <= 1'b0;
		meas(0);
		apb(1, ADOF_REG_CLK_CTRL, 32'h1);
		for (int n = 0; n < 2500 && dcs_locked !== 1'b1; n++) @(posedge clock);
		`CHK("locked", 1'b1, dcs_locked)
		apb(0, ADOF_REG_STATUS, 32'h0);
		`CHK("status", 2'h3, rd[1:0])
		for (int p = 0; p < 4; p++) begin
			apb(1, ADOF_REG_CLK_CTRL, 1 + 2 * p);
			repeat (64) @(posedge clock);
			meas(2 * p);
		end
		apb(1, ADOF_REG_CLK_CTRL, 32'hB);
		clk_inv <= 1'b1;
		repeat (64) @(posedge clock);
		meas(2);
		$display("test phase done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		mismatches++;
		wrap_up;
	end
	initial begin
		{mismatches, checks} = 0;
		{rst, clk_inv, core_over, core_under, config_mode_select, par_dcs_pin} = 6'h20;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		core_code = 12'h800;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_current;
		t_format;
		t_par;
		t_phase;
		wrap_up;
	end
endmodule
